// ==== logic/hscl_pkg.sv ====
// Overview of operation
// - host fills all eight pointer words
// - no normal operation before valid set
// - valid set latched, later writes ignored
// - link indicator green after valid set
// - position and drive refreshed every 2 ms
// - recirculations one, two or four per axis
// - interrogation polarity selectable per axis
// - position unsigned, 65535 maximum
// - drive is 12-bit converter code
// - velocity limited to 60000 units/s
package hscl_pkg;
  localparam int CFG_WORDS = 8;
  localparam int CFG_IDX_W = 3;
  localparam int WORD_W = 16;
  localparam int AXES = 4;
  localparam logic [CFG_IDX_W-1:0] IDX_AXIS1 = 3'h0;
  localparam logic [CFG_IDX_W-1:0] IDX_READBACK = 3'h4;
  localparam logic [CFG_IDX_W-1:0] IDX_COMMAND = 3'h5;
  localparam logic [CFG_IDX_W-1:0] IDX_RESERVED = 3'h6;
  localparam logic [CFG_IDX_W-1:0] IDX_CHECKSUM = 3'h7;
  localparam logic [CFG_WORDS-1:0] ALL_WRITTEN = 8'h00_ff;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int CTRL_PERIOD_US = 2000;
  localparam int CTRL_PERIOD_CYC = CLK_MHZ * CTRL_PERIOD_US;
  localparam int VEL_MAX_PER_S = 60000;
  localparam int STEP_MAX = (VEL_MAX_PER_S / 1000) * CTRL_PERIOD_US / 1000;
  // drive converter
  localparam int DAC_W = 12;
  localparam logic [DAC_W-1:0] DAC_MID = 12'h0800;
  localparam int ERR_LIM = 2047;
  localparam logic [WORD_W-1:0] POS_MAX = 16'hffff;
  // recirculation jumper codes; open jumpers give four
  localparam logic [1:0] RECIRC_FOUR = 2'h0;
  localparam logic [1:0] RECIRC_ONE = 2'h1;
  localparam logic [1:0] RECIRC_TWO = 2'h2;

  typedef enum logic {CFG_COLLECT, CFG_RUN} hscl_cfg_state_type;

  function automatic logic [1:0] hscl_recirc_shift(input logic [1:0] sel);
    logic [1:0] s;
    s = 2'h2;
    if (sel == RECIRC_ONE)
    begin
      s = 2'h0;
    end
    else if (sel == RECIRC_TWO)
    begin
      s = 2'h1;
    end
    return s;
  endfunction

  function automatic logic [WORD_W-1:0] hscl_sum7(input logic [WORD_W-1:0] w [CFG_WORDS]);
    logic [WORD_W-1:0] acc;
    acc = WORD_ZERO;
    for (int i = 0; i < CFG_WORDS - 1; i++)
    begin
      acc = acc + w[i];
    end
    return acc;
  endfunction
endpackage

// ==== logic/hscl_axis_if.sv ====
`timescale 1ns/100ps
interface hscl_axis_if;
  import hscl_pkg::*;
  logic tick;
  logic enable;
  logic [1:0] recirc_sel;
  logic neg_pol;
  logic [WORD_W-1:0] raw_count;
  logic [WORD_W-1:0] target;
  logic [WORD_W-1:0] position;
  logic [DAC_W-1:0] drive;
  logic interrogate;
  modport ctrl (output tick, output enable, output recirc_sel, output neg_pol,
    output raw_count, output target, input position, input drive, input interrogate);
  modport axis (input tick, input enable, input recirc_sel, input neg_pol,
    input raw_count, input target, output position, output drive, output interrogate);
endinterface

// ==== logic/hscl_axis.sv ====
`timescale 1ns/100ps
module hscl_axis
  import hscl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  hscl_axis_if.axis a
);
  localparam logic signed [WORD_W+1:0] STEP_S = (WORD_W+2)'(STEP_MAX);
  localparam logic signed [WORD_W+1:0] LIM_S = (WORD_W+2)'(ERR_LIM);

  logic [WORD_W-1:0] position;
  logic [WORD_W-1:0] setpoint;
  logic [DAC_W-1:0] drive;
  logic interrogate;
  logic [WORD_W-1:0] next_position;
  logic signed [WORD_W+1:0] diff;
  logic signed [WORD_W+1:0] err;
  logic [WORD_W-1:0] next_setpoint;

  assign a.position = position;
  assign a.drive = drive;
  assign a.interrogate = interrogate;

  // divide by recirculations; 16-bit result cannot pass full scale
  assign next_position = a.raw_count >> hscl_recirc_shift(a.recirc_sel);

  always_comb
  begin
    diff = $signed({2'b00, a.target}) - $signed({2'b00, setpoint});
    if (diff > STEP_S)
    begin
      next_setpoint = setpoint + WORD_W'(STEP_MAX);
    end
    else if (diff < -STEP_S)
    begin
      next_setpoint = setpoint - WORD_W'(STEP_MAX);
    end
    else
    begin
      next_setpoint = a.target;
    end
    err = $signed({2'b00, setpoint}) - $signed({2'b00, next_position});
    if (err > LIM_S)
    begin
      err = LIM_S;
    end
    else if (err < -LIM_S)
    begin
      err = -LIM_S;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      position <= WORD_ZERO;
      setpoint <= WORD_ZERO;
    end
    else if (!a.enable)
    begin
      // hold setpoint on the measured axis so enabling causes no jump
      setpoint <= next_position;
    end
    else if (a.tick)
    begin
      position <= next_position;
      setpoint <= next_setpoint;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      drive <= DAC_MID;
    end
    else if (!a.enable)
    begin
      drive <= DAC_MID;
    end
    else if (a.tick)
    begin
      drive <= DAC_MID + DAC_W'(err);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      interrogate <= 1'b0;
    end
    else
    begin
      interrogate <= (a.tick & a.enable) ^ a.neg_pol;
    end
  end
endmodule

// ==== logic/hscl_top.sv ====
`timescale 1ns/100ps
module hscl_top
  import hscl_pkg::*;
#(
  parameter int PERIOD_CYC = CTRL_PERIOD_CYC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic [CFG_IDX_W-1:0] cfg_index,
  input wire logic [WORD_W-1:0] cfg_wdata,
  input wire logic [CFG_IDX_W-1:0] cfg_rindex,
  output logic [WORD_W-1:0] cfg_rdata,
  output logic link_ok,
  output logic set_rejected,
  output logic control_tick,
  input wire logic [2*AXES-1:0] recirc_jumper,
  input wire logic [AXES-1:0] neg_pol_jumper,
  input wire logic [WORD_W*AXES-1:0] raw_count,
  input wire logic [WORD_W*AXES-1:0] target,
  output logic [WORD_W*AXES-1:0] position,
  output logic [DAC_W*AXES-1:0] drive_code,
  output logic [AXES-1:0] interrogate
);
  localparam logic [31:0] PERIOD_LAST = 32'(PERIOD_CYC - 1);

  hscl_cfg_state_type state;
  logic [WORD_W-1:0] shadow [CFG_WORDS];
  logic [WORD_W-1:0] latched [CFG_WORDS];
  logic [CFG_WORDS-1:0] written;
  logic set_good;
  logic [31:0] tick_cnt;
  logic [2*AXES-1:0] recirc_meta;
  logic [2*AXES-1:0] recirc_sync;
  logic [AXES-1:0] pol_meta;
  logic [AXES-1:0] pol_sync;

  // jumpers are asynchronous pins
  // reset value zero decodes as four recirculations, the open-jumper default
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      recirc_meta <= '0;
      recirc_sync <= '0;
    end
    else
    begin
      recirc_meta <= recirc_jumper;
      recirc_sync <= recirc_meta;
    end
  end

  // only the second flop feeds the axes
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pol_meta <= '0;
      pol_sync <= '0;
    end
    else
    begin
      pol_meta <= neg_pol_jumper;
      pol_sync <= pol_meta;
    end
  end

  // complete set, checksum over words one to seven, reserved word zero
  assign set_good = (written == ALL_WRITTEN)
    && (shadow[IDX_CHECKSUM] == hscl_sum7(shadow))
    && (shadow[IDX_RESERVED] == WORD_ZERO);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < CFG_WORDS; i++)
      begin
        shadow[i] <= WORD_ZERO;
      end
    end
    else if (state == CFG_COLLECT && cfg_wr)
    begin
      // once running, host writes are not sampled until reset
      shadow[cfg_index] <= cfg_wdata;
    end
  end

  // one flag per word; rewriting an index adds nothing
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      written <= '0;
    end
    else if (state == CFG_COLLECT && cfg_wr)
    begin
      written[cfg_index] <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state <= CFG_COLLECT;
    end
    else
    begin
      unique case (state)
        CFG_COLLECT:
        begin
          // set_good already folds in the checksum and the reserved word
          if (set_good)
          begin
            state <= CFG_RUN;
          end
        end
        CFG_RUN:
        begin
          // only a reset leaves this state
          state <= CFG_RUN;
        end
      endcase
    end
  end

  // level, not sticky: the host may rewrite any word and it is rechecked
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      set_rejected <= 1'b0;
    end
    else
    begin
      set_rejected <= (state == CFG_COLLECT) && (written == ALL_WRITTEN) && !set_good;
    end
  end

  // copy taken on the accepting edge only; shadow is frozen after it
  // so readback shows the accepted set, never later host writes
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < CFG_WORDS; i++)
      begin
        latched[i] <= WORD_ZERO;
      end
    end
    else if (state == CFG_COLLECT && set_good)
    begin
      latched <= shadow;
    end
  end

  assign link_ok = (state == CFG_RUN);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cfg_rdata <= WORD_ZERO;
    end
    else
    begin
      cfg_rdata <= latched[cfg_rindex];
    end
  end

  // control period counter only runs once configured
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tick_cnt <= '0;
    end
    // cleared while collecting, so the first period is full length
    else if (state != CFG_RUN || tick_cnt == PERIOD_LAST)
    begin
      tick_cnt <= '0;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // registered so every axis sees the same single-cycle pulse
  // counts 0 to PERIOD_LAST, giving one tick every PERIOD_CYC edges
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      control_tick <= 1'b0;
    end
    else
    begin
      control_tick <= (state == CFG_RUN) && (tick_cnt == PERIOD_LAST);
    end
  end

  hscl_axis_if ax [AXES] ();

  for (genvar g = 0; g < AXES; g++)
  begin : g_axis
    assign ax[g].tick = control_tick;
    assign ax[g].enable = link_ok;
    assign ax[g].recirc_sel = recirc_sync[2*g +: 2];
    assign ax[g].neg_pol = pol_sync[g];
    assign ax[g].raw_count = raw_count[WORD_W*g +: WORD_W];
    assign ax[g].target = target[WORD_W*g +: WORD_W];
    assign position[WORD_W*g +: WORD_W] = ax[g].position;
    assign drive_code[DAC_W*g +: DAC_W] = ax[g].drive;
    assign interrogate[g] = ax[g].interrogate;

    hscl_axis u_axis
    (
      .mclk(mclk),
      .rst_n(rst_n),
      .a(ax[g])
    );
  end
endmodule

// ==== bench/hscl_sva.sv ====
`timescale 1ns/100ps
module hscl_sva
  import hscl_pkg::*;
#(
  parameter int PERIOD_CYC = 50
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WORD_W-1:0] cfg_rdata,
  input wire logic link_ok,
  input wire logic set_rejected,
  input wire logic control_tick,
  input wire logic [AXES-1:0] neg_pol_jumper,
  input wire logic [DAC_W*AXES-1:0] drive_code,
  input wire logic [AXES-1:0] interrogate
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  int cnt;
  // cycles since link came up or since the last tick
  always_ff @(posedge mclk)
    cnt <= (!rst_n || !link_ok || control_tick) ? 0 : cnt + 1;
  a_link_holds: assert property (link_ok |=> link_ok)
    else $error("link dropped");
  a_tick_link: assert property (control_tick |-> link_ok)
    else $error("tick without link");
  a_tick_spacing: assert property (control_tick |-> cnt >= PERIOD_CYC - 1)
    else $error("tick too early");
  a_tick_due: assert property (link_ok |-> cnt <= PERIOD_CYC)
    else $error("tick missing");
  a_reject_unlinked: assert property (set_rejected |-> !link_ok)
    else $error("rejected set linked");
  a_rdata_idle: assert property (!link_ok |-> cfg_rdata == WORD_ZERO)
    else $error("readback before link");
  a_drive_idle: assert property (!link_ok |-> drive_code == {AXES{DAC_MID}})
    else $error("drive moved before link");
  a_drive_hold: assert property (!control_tick |=> $stable(drive_code))
    else $error("drive changed off tick");
  a_probe_pulse: assert property (control_tick |=> interrogate == ~neg_pol_jumper
    ##1 interrogate == neg_pol_jumper) else $error("probe pulse wrong");
  c_link: cover property ($rose(link_ok));
  c_reject: cover property ($rose(set_rejected));
  c_tick: cover property (control_tick);
endmodule
bind hscl_top hscl_sva #(.PERIOD_CYC(PERIOD_CYC)) u_hscl_sva (.mclk(mclk), .rst_n(rst_n),
  .cfg_rdata(cfg_rdata), .link_ok(link_ok), .set_rejected(set_rejected),
  .control_tick(control_tick), .neg_pol_jumper(neg_pol_jumper),
  .drive_code(drive_code), .interrogate(interrogate));

// ==== bench/hscl_host_model.sv ====
`timescale 1ns/100ps
module hscl_host_model
  import hscl_pkg::*;
(
  input wire logic mclk,
  output logic cfg_wr,
  output logic [CFG_IDX_W-1:0] cfg_index,
  output logic [WORD_W-1:0] cfg_wdata
);
  initial
  begin
    cfg_wr = 1'b0;
    cfg_index = 3'h0;
    cfg_wdata = 16'h0000;
  end
  // one word per strobe; data inverted once released
  task automatic put(input logic [CFG_IDX_W-1:0] i, input logic [WORD_W-1:0] d);
    @(negedge mclk);
    cfg_wr = 1'b1;
    cfg_index = i;
    cfg_wdata = d;
    @(negedge mclk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask
endmodule

// ==== bench/hscl_top_tb.sv ====
`timescale 1ns/100ps
module hscl_top_tb;
  import hscl_pkg::*;
  localparam int PCYC = 50;
  logic mclk, rst_n, cfg_wr, link_ok, set_rejected, control_tick;
  logic [CFG_IDX_W-1:0] cfg_index, cfg_rindex;
  logic [WORD_W-1:0] cfg_wdata, cfg_rdata, s;
  logic [2*AXES-1:0] recirc_jumper;
  logic [AXES-1:0] neg_pol_jumper, interrogate;
  logic [WORD_W*AXES-1:0] raw_count, target, position;
  logic [DAC_W*AXES-1:0] drive_code;
  logic [WORD_W-1:0] w [8];
  int errors, compares, cyc;
  hscl_top #(.PERIOD_CYC(PCYC)) u_hscl_top (.mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr),
    .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rindex(cfg_rindex),
    .cfg_rdata(cfg_rdata), .link_ok(link_ok), .set_rejected(set_rejected),
    .control_tick(control_tick), .recirc_jumper(recirc_jumper),
    .neg_pol_jumper(neg_pol_jumper), .raw_count(raw_count), .target(target),
    .position(position), .drive_code(drive_code), .interrogate(interrogate));
  hscl_host_model u_hscl_host_model (.mclk(mclk), .cfg_wr(cfg_wr), .cfg_index(cfg_index),
    .cfg_wdata(cfg_wdata));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [WORD_W-1:0] exp_pos(logic [WORD_W-1:0] r, logic [1:0] c);
    return c == 2'h1 ? r : (c == 2'h2 ? r >> 1 : r >> 2);
  endfunction
  task automatic put(input int i, input logic [WORD_W-1:0] d);
    u_hscl_host_model.put(3'(i), d);
    @(negedge mclk);
  endtask
  task automatic tick();
    for (int n = 0; n < 2 * PCYC && control_tick !== 1'b1; n++)
      @(negedge mclk);
    chk(control_tick, 1'b1);
    @(negedge mclk);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      errors++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(32'hf5fa));
    cfg_rindex = 3'h0;
    // every recirculation code on some axis, mixed polarity
    recirc_jumper = 8'b1110_0100;
    neg_pol_jumper = 4'b0101;
    target = {AXES{16'hf000}};
    for (int r = 0; r < 2; r++)
    begin
      rst_n = 1'b0;
      for (int g = 0; g < AXES; g++)
        raw_count[16*g+:16] = 16'($urandom) & 16'h3fff;
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      s = 16'h0000;
      for (int i = 0; i < 6; i++)
      begin
        w[i] = r == 0 ? 16'(201 + 50 * i) : 16'($urandom);
        s = s + w[i];
      end
      w[6] = 16'h0000;
      w[7] = s;
      for (int i = 0; i < 7; i++)
        put(i, w[i]);
      chk({link_ok, set_rejected}, 2'b00);
      put(7, s + 16'h0001);
      chk({link_ok, set_rejected}, 2'b01);
      put(6, 16'h0001);
      chk({link_ok, set_rejected}, 2'b01);
      put(6, 16'h0000);
      put(7, s);
      chk({link_ok, set_rejected}, 2'b10);
      put(0, ~w[0]);
      for (int i = 0; i < 8; i++)
      begin
        cfg_rindex = 3'(i);
        @(negedge mclk);
        chk(cfg_rdata, w[i]);
      end
      chk(interrogate, neg_pol_jumper);
      // error grows by one velocity-limited step per tick, gain one
      tick();
      for (int g = 0; g < AXES; g++)
        chk(drive_code[12*g+:12], DAC_MID);
      tick();
      for (int g = 0; g < AXES; g++)
        chk(drive_code[12*g+:12], DAC_MID + 12'(STEP_MAX));
      tick();
      for (int g = 0; g < AXES; g++)
      begin
        chk(position[16*g+:16], exp_pos(raw_count[16*g+:16], recirc_jumper[2*g+:2]));
        chk(drive_code[12*g+:12], DAC_MID + 12'(2 * STEP_MAX));
      end
      recirc_jumper = 8'($urandom);
      neg_pol_jumper = 4'($urandom);
    end
    print_verdict();
  end
endmodule
